// *** fpw_cfg.svh ***
// Constants of the flash page write controller: map, register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef FPW_CFG_SVH
`define FPW_CFG_SVH
// ----------------------------------------------------------------------
// Flash window
// ----------------------------------------------------------------------
`define FPW_BASE 16'h4000
`define FPW_SIZE 49152
`define FPW_PAGES 384
`define FPW_PAGE_BYTES 128
`define FPW_LAST_IDX 7'h7f
`define FPW_FILL 8'hff
`define FPW_WE_KEY 4'h3
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FPW_CTRL_OFS 32'h0000_0000
`define FPW_STAT_OFS 32'h0000_0004
`define FPW_EMU_OFS 32'h0000_0008
`define FPW_IRQ_ST_OFS 32'h0000_000c
`define FPW_IRQ_MASK_OFS 32'h0000_0010
// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FPW_CTRL_WE_LSB 4
`define FPW_CTRL_STOP_BIT 2
`define FPW_CTRL_PWR_BIT 0
`define FPW_STAT_BUSY_BIT 1
`define FPW_STAT_PRDY_BIT 0
`define FPW_IRQ_DONE_BIT 0
`define FPW_IRQ_REFUSE_BIT 1
`define FPW_IRQ_ABORT_BIT 2
`define FPW_CTRL_WE_RST 4'hc
`define FPW_CTRL_PWR_RST 1'b1
`define FPW_EMU_RST 3'h0
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FPW_CLK_MHZ 100
`define FPW_OSC_MHZ 1
`define FPW_OSC_DIV (`FPW_CLK_MHZ / `FPW_OSC_MHZ)
`define FPW_PROG_TIME_US 4000
`define FPW_PROG_TICKS (`FPW_PROG_TIME_US * `FPW_OSC_MHZ)
`define FPW_PWR_UP_TICKS 3'h4
`endif

// *** fpw_pkg.sv ***
// Types shared by the flash page write controller.
// Assumes nothing beyond a SystemVerilog compiler.
package fpw_pkg;
  // CPU cycle toward the flash window
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fpw_req_type;
  // Answer to a read or fetch
  typedef struct packed {
    logic rvalid;
    logic [7:0] rdata;
    logic swi;
  } fpw_rsp_type;
  // Sequencer states
  typedef enum logic [2:0] {
    FPW_IDLE = 3'b001,
    FPW_FILL = 3'b010,
    FPW_PROG = 3'b100
  } fpw_state_type;
endpackage : fpw_pkg

// *** fpw_sync.sv ***
// Three-stage synchroniser for a pin level.
// Assumes one clock; output moves once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module fpw_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin and clean level
  input wire logic pin,
  output logic level
);
  logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt; // Stages and output
  // Accept a change only when two stages agree
  always_comb
  begin
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  end
  // Register stages
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end
  assign level = lvl_r;
endmodule : fpw_sync
`default_nettype wire

// *** fpw_tick.sv ***
// Divider that stands in for the dedicated flash oscillator.
// Assumes the system clock; gives a one-cycle tick every DIV cycles.
`timescale 1ns/1ns
`default_nettype none
module fpw_tick #(
  parameter int unsigned DIV = 100
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Tick out
  output logic tick
);
  logic [15:0] cnt_r, cnt_nxt; // Cycle count
  logic tick_r, tick_nxt; // Registered pulse
  // Count up through the period
  always_comb
  begin
    tick_nxt = (cnt_r == 16'(DIV - 1));
    cnt_nxt = tick_nxt ? 16'h0000 : cnt_r + 16'h0001;
  end
  // Register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick = tick_r;
endmodule : fpw_tick
`default_nettype wire

// *** fpw_ctrl.sv ***
// Flash page write controller: CPU window, page buffer, self-timed
// erase-and-program, AXI4-Lite register slave and interrupt.
// Assumes the CPU and AXI master run on clk; mode pin is asynchronous.
`include "fpw_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Flash window is 48K bytes, 4000h-FFFFh
// - 384 pages of 128 bytes each
// - Accepted writes land in page buffer
// - 128th byte starts whole-page program
// - Page erased automatically at program start
// - Program timed by flash oscillator ticks
// - Flash power may be switched off
// - Normal/slow modes: reads and fetches only
// - Writes accepted only in serial mode
// - Any byte readable individually
// - Busy: reads and fetches return FFh
// - Fetched filler while busy raises soft interrupt
// - Write needs key 0011, power ready, no program running
// - Emulation timing register is storage only
// - Control fields locked while running from flash
// - Forced stop aborts filling or programming
module fpw_ctrl #(
  parameter int unsigned PROG_TICKS = `FPW_PROG_TICKS,
  parameter int unsigned OSC_DIV = `FPW_OSC_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // CPU side
  input wire fpw_pkg::fpw_req_type cpu_req,
  input wire logic exec_from_flash,
  output fpw_pkg::fpw_rsp_type cpu_rsp,
  // Mode pin
  input wire logic serial_mode_pin,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash supply and interrupt
  output logic flash_power_on,
  output logic irq
);
  // --------------------------------------------------------------------
  // Storage and state
  // --------------------------------------------------------------------
  logic [7:0] mem [0:`FPW_SIZE-1]; // Flash array
  logic [7:0] pbuf [0:`FPW_PAGE_BYTES-1]; // Temporary page buffer
  fpw_pkg::fpw_state_type state_r, state_nxt; // Sequencer
  logic [8:0] page_r, page_nxt; // Target page
  logic [6:0] cnt_r, cnt_nxt; // Bytes taken since the page began
  logic [19:0] tk_r, tk_nxt; // Oscillator ticks in program
  logic [3:0] we_key_r, we_key_nxt; // Write-enable field
  logic pwr_r, pwr_nxt; // Power-control field
  logic [2:0] pup_r, pup_nxt; // Power-up settle count
  logic [2:0] emu_r, emu_nxt; // Emulation timing register
  logic [2:0] ist_r, ist_nxt; // Interrupt status
  logic [2:0] imask_r, imask_nxt; // Interrupt mask
  logic irq_r, irq_nxt; // Interrupt output
  fpw_pkg::fpw_rsp_type rsp_r, rsp_nxt; // CPU answer
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt; // AXI holds
  logic [31:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  logic serial_mode, osc_tick; // Clean mode, oscillator tick
  logic in_win, busy, pwr_rdy, wr_ok, buf_we, start_prog, finish_prog;
  logic do_wr, ctrl_wr, stop_req, abort;
  logic [15:0] ofs; // Offset in window
  logic [7:0] rd_byte; // Stored byte at offset
  logic [2:0] ev; // Interrupt events
  // Mode pin through three stages
  fpw_sync u_mode (
    .clk(clk),
    .rst_b(rst_b),
    .pin(serial_mode_pin),
    .level(serial_mode)
  );
  // Flash oscillator
  fpw_tick #(.DIV(OSC_DIV)) u_osc (
    .clk(clk),
    .rst_b(rst_b),
    .tick(osc_tick)
  );
  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb
  begin
    // Window decode: upper bound is the top of the 16-bit space
    in_win = cpu_req.valid && (cpu_req.addr >= `FPW_BASE);
    ofs = in_win ? cpu_req.addr - `FPW_BASE : 16'h0000;
    rd_byte = mem[ofs];
    busy = (state_r != fpw_pkg::FPW_IDLE);
    pwr_rdy = pwr_r && (pup_r == `FPW_PWR_UP_TICKS);
    // Filling continues under busy; a running program refuses
    wr_ok = serial_mode && (we_key_r == `FPW_WE_KEY) && pwr_rdy
            && (state_r != fpw_pkg::FPW_PROG);
    buf_we = in_win && cpu_req.write && wr_ok;
    // AXI write completes when both halves are held
    do_wr = aw_full_r && w_full_r && !bvalid_r;
    ctrl_wr = do_wr && (awaddr_r == `FPW_CTRL_OFS) && wstrb0_r;
    stop_req = ctrl_wr && !exec_from_flash && wdata_r[`FPW_CTRL_STOP_BIT];
    abort = busy && (stop_req || !pwr_r);
    // The 128th accepted byte starts the program, whatever its index
    start_prog = buf_we && !abort && (cnt_r == `FPW_LAST_IDX);
    finish_prog = (state_r == fpw_pkg::FPW_PROG) && osc_tick && !abort
                  && (tk_r == 20'(PROG_TICKS - 1));
    // Defaults
    state_nxt = state_r;
    page_nxt = page_r;
    tk_nxt = tk_r;
    we_key_nxt = we_key_r;
    pwr_nxt = pwr_r;
    emu_nxt = emu_r;
    imask_nxt = imask_r;
    ev = 3'h0;
    // Sequencer
    case (state_r)
      fpw_pkg::FPW_IDLE:
      begin
        if (buf_we)
        begin
          page_nxt = ofs[15:7];
          state_nxt = start_prog ? fpw_pkg::FPW_PROG : fpw_pkg::FPW_FILL;
        end
      end
      fpw_pkg::FPW_FILL:
      begin
        if (start_prog)
        begin
          state_nxt = fpw_pkg::FPW_PROG;
        end
      end
      fpw_pkg::FPW_PROG:
      begin
        if (osc_tick)
        begin
          tk_nxt = tk_r + 20'h00001;
        end
        if (finish_prog)
        begin
          state_nxt = fpw_pkg::FPW_IDLE;
          ev[`FPW_IRQ_DONE_BIT] = 1'b1;
        end
      end
      default:
      begin
        state_nxt = fpw_pkg::FPW_IDLE;
      end
    endcase
    if (start_prog)
    begin
      tk_nxt = 20'h00000;
    end
    // Byte count restarts with every page and on abort
    if (abort || start_prog)
    begin
      cnt_nxt = 7'h00;
    end
    else if (buf_we)
    begin
      cnt_nxt = cnt_r + 7'h01;
    end
    else
    begin
      cnt_nxt = cnt_r;
    end
    if (abort)
    begin
      state_nxt = fpw_pkg::FPW_IDLE;
      ev[`FPW_IRQ_ABORT_BIT] = 1'b1;
    end
    if (in_win && cpu_req.write && !wr_ok)
    begin
      ev[`FPW_IRQ_REFUSE_BIT] = 1'b1;
    end
    // Power settle counts oscillator ticks
    if (!pwr_r)
    begin
      pup_nxt = 3'h0;
    end
    else if (osc_tick && !pwr_rdy)
    begin
      pup_nxt = pup_r + 3'h1;
    end
    else
    begin
      pup_nxt = pup_r;
    end
    // CPU answer: filler while busy, soft interrupt on filler fetch
    rsp_nxt.rvalid = in_win && !cpu_req.write;
    rsp_nxt.rdata = busy ? `FPW_FILL : rd_byte;
    rsp_nxt.swi = in_win && !cpu_req.write && cpu_req.fetch && busy;
    // AXI write channel
    aw_full_nxt = aw_full_r || (s_axi_awvalid && awready_r);
    w_full_nxt = w_full_r || (s_axi_wvalid && wready_r);
    awaddr_nxt = (s_axi_awvalid && awready_r) ? s_axi_awaddr : awaddr_r;
    wdata_nxt = (s_axi_wvalid && wready_r) ? s_axi_wdata : wdata_r;
    wstrb0_nxt = (s_axi_wvalid && wready_r) ? s_axi_wstrb[0] : wstrb0_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    ist_nxt = ist_r;
    if (do_wr)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = 2'b00;
      if (ctrl_wr && !exec_from_flash)
      begin
        we_key_nxt = wdata_r[`FPW_CTRL_WE_LSB +: 4];
        pwr_nxt = wdata_r[`FPW_CTRL_PWR_BIT];
      end
      if (wstrb0_r)
      begin
        case (awaddr_r)
          `FPW_CTRL_OFS, `FPW_STAT_OFS:
          begin
          end
          `FPW_EMU_OFS: emu_nxt = wdata_r[2:0];
          `FPW_IRQ_ST_OFS: ist_nxt = ist_r & ~wdata_r[2:0];
          `FPW_IRQ_MASK_OFS: imask_nxt = wdata_r[2:0];
          default: bresp_nxt = 2'b10;
        endcase
      end
    end
    ist_nxt = ist_nxt | ev; // Set wins over clear
    irq_nxt = |(ist_r & imask_r);
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt = !w_full_nxt && !bvalid_nxt;
    // AXI read channel
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'b00;
      case (s_axi_araddr)
        `FPW_CTRL_OFS: rdata_nxt = {24'h000000, we_key_r, 3'h0, pwr_r};
        `FPW_STAT_OFS: rdata_nxt = {30'h00000000, busy, pwr_rdy};
        `FPW_EMU_OFS: rdata_nxt = {29'h00000000, emu_r};
        `FPW_IRQ_ST_OFS: rdata_nxt = {29'h00000000, ist_r};
        `FPW_IRQ_MASK_OFS: rdata_nxt = {29'h00000000, imask_r};
        default:
        begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = 2'b10;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end
  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= fpw_pkg::FPW_IDLE;
      page_r <= 9'h000;
      cnt_r <= 7'h00;
      tk_r <= 20'h00000;
      we_key_r <= `FPW_CTRL_WE_RST;
      pwr_r <= `FPW_CTRL_PWR_RST;
      pup_r <= 3'h0;
      emu_r <= `FPW_EMU_RST;
      ist_r <= 3'h0;
      imask_r <= 3'h0;
      irq_r <= 1'b0;
      rsp_r <= '0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'b00;
    end
    else
    begin
      state_r <= state_nxt;
      page_r <= page_nxt;
      cnt_r <= cnt_nxt;
      tk_r <= tk_nxt;
      we_key_r <= we_key_nxt;
      pwr_r <= pwr_nxt;
      pup_r <= pup_nxt;
      emu_r <= emu_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      irq_r <= irq_nxt;
      rsp_r <= rsp_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  // --------------------------------------------------------------------
  // Page buffer and array: erase at start, whole page at finish
  // --------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (buf_we && !abort)
    begin
      pbuf[ofs[6:0]] <= cpu_req.wdata;
    end
    if (start_prog)
    begin
      for (int i = 0; i < `FPW_PAGE_BYTES; i++)
      begin
        mem[{page_nxt, 7'(i)}] <= `FPW_FILL;
      end
    end
    if (finish_prog)
    begin
      for (int i = 0; i < `FPW_PAGE_BYTES; i++)
      begin
        mem[{page_r, 7'(i)}] <= pbuf[i];
      end
    end
  end
  // Outputs
  assign cpu_rsp = rsp_r;
  assign flash_power_on = pwr_r;
  assign irq = irq_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence seq_last_write;
    buf_we && !abort && (cnt_r == `FPW_LAST_IDX);
  endsequence
  sequence seq_prog_runs;
    (state_r == fpw_pkg::FPW_PROG) && busy;
  endsequence
  a_busy_read_fill: assert property (in_win && !cpu_req.write && busy
    |=> cpu_rsp.rvalid && cpu_rsp.rdata == `FPW_FILL)
    else $error("busy read not filler");
  a_fetch_soft_int: assert property (in_win && cpu_req.fetch
    && !cpu_req.write && busy |=> cpu_rsp.swi)
    else $error("no soft interrupt on busy fetch");
  a_page_prog_start: assert property (seq_last_write |=> seq_prog_runs)
    else $error("program did not start");
  a_prog_tick_len: assert property ($fell(state_r == fpw_pkg::FPW_PROG)
    && !$past(abort) |-> $past(tk_r) == 20'(PROG_TICKS - 1))
    else $error("program length wrong");
  a_refused_idle: assert property (state_r == fpw_pkg::FPW_IDLE && in_win
    && cpu_req.write && !wr_ok |=> !busy)
    else $error("refused write changed state");
  a_ctrl_lock: assert property (ctrl_wr && exec_from_flash
    |=> $stable(we_key_r) && $stable(pwr_r))
    else $error("control changed from flash");
  // A fresh accepted write right after the abort may start a new page
  a_stop_abort: assert property (stop_req && busy
    |=> !busy ##1 (!busy || $past(buf_we)))
    else $error("forced stop ignored");
  // Sequencer leaves idle only on a write made under all enables
  a_key_gate: assert property ($rose(busy)
    |-> $past(we_key_r) == `FPW_WE_KEY && $past(pwr_rdy) && $past(serial_mode))
    else $error("write taken without enables");
  a_emu_store: assert property (do_wr && wstrb0_r && awaddr_r == `FPW_EMU_OFS
    |=> emu_r == $past(wdata_r[2:0]))
    else $error("timing register not stored");
endmodule : fpw_ctrl
`default_nettype wire

// *** fpw_cpu_model.sv ***
// CPU core model: issues flash window reads, fetches and write bursts.
// Assumes the controller samples cpu_req on the rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module fpw_cpu_model (
  // Clock
  input wire logic clk,
  // Cycle out, answer in
  output var fpw_pkg::fpw_req_type cpu_req,
  input wire fpw_pkg::fpw_rsp_type cpu_rsp
);
  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial cpu_req = '0;

  // Back-to-back bytes; valid stays up through the burst
  task automatic wr_burst(input logic [15:0] a, input logic [7:0] q [$]);
    int i;
    for (i = 0; i < q.size(); i++)
    begin
      cpu_req <= {1'b1, 1'b1, 1'b0, a + 16'(i), q[i]};
      @(posedge clk);
    end
    // Released data shows the inverse, never the last byte
    cpu_req.valid <= 1'b0;
    cpu_req.wdata <= ~cpu_req.wdata;
    cpu_req.addr <= ~cpu_req.addr;
    @(posedge clk);
  endtask : wr_burst

  // One read or fetch; answer awaited for a few edges only
  task automatic rd(input logic [15:0] a, input logic f, output logic [7:0] d,
                    output logic s, output logic ok);
    int n;
    cpu_req <= {1'b1, 1'b0, f, a, 8'h00};
    @(posedge clk);
    cpu_req.valid <= 1'b0;
    cpu_req.addr <= ~a;
    ok = 1'b0;
    d = 8'h00;
    s = 1'b0;
    for (n = 0; n < 3 && !ok; n++)
    begin
      @(posedge clk);
      // Answer pulse stands one cycle
      if (cpu_rsp.rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = cpu_rsp.rdata;
        s = cpu_rsp.swi;
      end
    end
  endtask : rd
endmodule : fpw_cpu_model
`default_nettype wire

// *** flash_page_write_control_tb.sv ***
// Self-checking bench of the flash page write controller.
// Assumes fpw_cpu_model on the CPU side and an AXI4-Lite master here.
`include "fpw_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module flash_page_write_control_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic exec_from_flash = 1'b0;
  logic serial_mode_pin = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic flash_power_on, irq;
  fpw_pkg::fpw_req_type cpu_req;
  fpw_pkg::fpw_rsp_type cpu_rsp;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] rd_word;
  logic [1:0] resp;
  int mem [int]; // Expected array contents
  logic [7:0] q [$];
  logic [7:0] q1 [$];
  logic [7:0] rb;
  logic swi_got, ok;
  int i, p;

  always #5 clk = ~clk;

  // Short program and power-up times
  fpw_ctrl #(.PROG_TICKS(3), .OSC_DIV(4)) fpw_ctrl_inst (
    .clk(clk), .rst_b(rst_b), .cpu_req(cpu_req), .exec_from_flash(exec_from_flash),
    .cpu_rsp(cpu_rsp), .serial_mode_pin(serial_mode_pin),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .flash_power_on(flash_power_on), .irq(irq)
  );
  fpw_cpu_model fpw_cpu_model_inst (.clk(clk), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));

  // ----------------------------------------------------------------
  // Compare, bus and polling tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (!ad && s_axi_awready === 1'b1)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd_word = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  // Status bit polled until it reaches v, with a bounded count
  task automatic poll(input int b, input logic v);
    int n;
    for (n = 0; n < 40; n++)
    begin
      axi_rd(`FPW_STAT_OFS);
      if (rd_word[b] === v) break;
    end
    chk_bit(rd_word[b], v);
  endtask : poll

  // Sticky events checked, interrupt seen, then cleared by write-one
  task automatic irq_take(input logic [31:0] exp);
    axi_rd(`FPW_IRQ_ST_OFS);
    chk_word(rd_word & 32'h7, exp);
    chk_bit(irq, |exp);
    axi_wr(`FPW_IRQ_ST_OFS, rd_word);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0);
  endtask : irq_take

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(93));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset values and the storage-only register
    axi_rd(`FPW_CTRL_OFS);
    chk_word(rd_word & 32'hf5, 32'hc1);
    chk_bit(flash_power_on, 1'b1);
    axi_rd(`FPW_EMU_OFS);
    chk_word(rd_word, 32'h0);
    p = $urandom_range(7);
    axi_wr(`FPW_EMU_OFS, 32'(p));
    axi_rd(`FPW_EMU_OFS);
    chk_word(rd_word, 32'(p));
    // Byte lane 0 off: answered with OKAY, nothing stored
    s_axi_wstrb <= 4'he;
    axi_wr(`FPW_EMU_OFS, 32'(~p));
    s_axi_wstrb <= 4'hf;
    chk_word(32'(resp), 32'h0);
    axi_rd(`FPW_EMU_OFS);
    chk_word(rd_word, 32'(p));
    // Unmapped place answers with an error response
    axi_rd(32'h0000_0040);
    chk_word(32'(resp), 32'h2);
    axi_wr(32'h0000_0040, 32'h1);
    chk_word(32'(resp), 32'h2);
    axi_wr(`FPW_IRQ_MASK_OFS, 32'h7);
    poll(`FPW_STAT_PRDY_BIT, 1'b1);
    // Key write while running from flash is ignored
    exec_from_flash <= 1'b1;
    axi_wr(`FPW_CTRL_OFS, 32'h31);
    exec_from_flash <= 1'b0;
    axi_rd(`FPW_CTRL_OFS);
    chk_word(rd_word & 32'hf0, 32'hc0);
    axi_wr(`FPW_CTRL_OFS, 32'h31);
    // Normal mode refuses the write and stores nothing
    q1 = {8'h5a};
    fpw_cpu_model_inst.wr_burst(16'h4000, q1);
    irq_take(32'h2);
    poll(`FPW_STAT_BUSY_BIT, 1'b0);
    // Serial mode; below the window nothing is taken
    serial_mode_pin <= 1'b1;
    repeat (8) @(posedge clk);
    fpw_cpu_model_inst.wr_burst(16'h3fff, q1);
    fpw_cpu_model_inst.rd(16'h3fff, 1'b0, rb, swi_got, ok);
    chk_bit(ok, 1'b0);
    poll(`FPW_STAT_BUSY_BIT, 1'b0);
    // Last page twice, second pass inverted so erase is needed
    for (i = 0; i < 128; i++) q.push_back(8'($urandom));
    for (p = 0; p < 2; p++)
    begin
      if (p == 1) foreach (q[j]) q[j] = ~q[j];
      fpw_cpu_model_inst.wr_burst(16'hff80, q[0:63]);
      fpw_cpu_model_inst.rd(16'hff80, 1'b0, rb, swi_got, ok);
      chk_word({24'h0, rb}, 32'hff);
      fpw_cpu_model_inst.rd(16'hff81, 1'b1, rb, swi_got, ok);
      chk_bit(swi_got, 1'b1);
      fpw_cpu_model_inst.wr_burst(16'hffc0, q[64:127]);
      // Write while programming is refused
      q1 = {~q[0]};
      fpw_cpu_model_inst.wr_burst(16'hff80, q1);
      poll(`FPW_STAT_BUSY_BIT, 1'b0);
      irq_take(32'h3);
      for (i = 0; i < 128; i++) mem[16'hff80 + i] = q[i];
      for (i = 0; i < 128; i++)
      begin
        fpw_cpu_model_inst.rd(16'hff80 + 16'(i), 1'b0, rb, swi_got, ok);
        chk_word({24'h0, rb}, 32'(mem[16'hff80 + i]));
      end
    end
    // Forced stop in mid-fill, issued from RAM
    fpw_cpu_model_inst.wr_burst(16'h4000, q[0:15]);
    axi_rd(`FPW_STAT_OFS);
    chk_bit(rd_word[`FPW_STAT_BUSY_BIT], 1'b1);
    axi_wr(`FPW_CTRL_OFS, 32'h35);
    poll(`FPW_STAT_BUSY_BIT, 1'b0);
    irq_take(32'h4);
    // Locked key, then power off, each refuse the write
    axi_wr(`FPW_CTRL_OFS, 32'hc1);
    fpw_cpu_model_inst.wr_burst(16'h4100, q1);
    irq_take(32'h2);
    axi_wr(`FPW_CTRL_OFS, 32'h30);
    chk_bit(flash_power_on, 1'b0);
    poll(`FPW_STAT_PRDY_BIT, 1'b0);
    // Masked event keeps the interrupt low until unmasked
    axi_wr(`FPW_IRQ_MASK_OFS, 32'h0);
    fpw_cpu_model_inst.wr_burst(16'h4100, q1);
    repeat (4) @(posedge clk);
    chk_bit(irq, 1'b0);
    axi_wr(`FPW_IRQ_MASK_OFS, 32'h2);
    repeat (3) @(posedge clk);
    irq_take(32'h2);
    summarize();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #500000;
    error_cnt++;
    $display("CHECK FAILED at %0t: timeout", $time);
    summarize();
  end
endmodule : flash_page_write_control_tb
`default_nettype wire
